// ---- cmx_exec.sv ----
/*
 Execution core for byte and bit moves, data pointer load, code table reads,
 external data transfers, unsigned multiply and the idle instruction.
 Opcodes outside this subset are skipped as one-byte instructions and flagged.
 Assumes CODE_DATA holds the three program bytes at CODE_ADDR in the same cycle,
 and an external memory on the multiplexed port that latches the address on ALE.
 Read data on P0_IN must stand for as long as the read strobe is low.
*/
// Functional notes
// - Byte copy writes only destination; source, other registers and flags stay.
// - Opcode e5 plus direct byte loads accumulator; two bytes, one cycle.
// - Opcode 74 plus immediate byte loads that constant into accumulator.
// - Opcodes a8-af plus direct byte load working register; two cycles.
// - Opcodes 78-7f plus immediate load working register; two bytes, one cycle.
// - Opcodes a6/a7 store direct byte into RAM at pointer register address.
// - Direct-to-direct copy: source address byte two, destination byte three.
// - Bit copies only between carry and a directly addressable bit.
// - Data pointer load: byte two high, byte three low; three bytes, two cycles.
// - Table read fetches code at accumulator plus 16-bit base into accumulator.
// - PC-based table read advances PC first; pointer base stays unaltered.
// - External transfers move one byte either way, 8 or 16-bit address.
// - Register-indirect form puts R0/R1 address on port zero before data.
// - Pointer form: high byte on port two, low byte with data on port zero.
// - Port two latch is kept and restored while it carries the address.
// - Multiply: low product byte to accumulator, high to B; four cycles.
// - Multiply sets overflow when product exceeds 255, else clears it.
// - Multiply always clears carry.
// - Idle instruction only advances the program counter.
`timescale 1ns/1ps
`default_nettype none
module cmx_exec
    import cmx_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        RSTN,
    output logic      [15:0] CODE_ADDR,
    input  wire logic [23:0] CODE_DATA,
    input  wire logic [7:0]  P0_IN,
    output cmx_xbus_t        XBUS,
    output cmx_core_t        CORE,
    output logic             INSN_DONE,
    output logic             INSN_UNKNOWN
);
    typedef struct packed {
        logic [255:0][7:0] ram;
        logic [7:0]        acc;
        logic [7:0]        b;
        logic [7:0]        psw;
        logic [7:0]        pointer_high_byte;
        logic [7:0]        pointer_low_byte;
        logic [7:0]        p2;
        logic [15:0]       pc;
        logic [15:0]       code_addr;
        cmx_fsm_t          fsm;
        logic [2:0]        cnt;
        logic              xwr;
        logic              xdptr;
        logic [7:0]        p0_meta;
        logic [7:0]        p0_sync;
        cmx_xbus_t         xbus;
        logic              done;
        logic              bad;
    } cmx_state_t;

    cmx_state_t s_reg;
    cmx_state_t s_next;
    cmx_dec_t   dec;
    logic [7:0] op;
    logic [7:0] byte2;
    logic [7:0] byte3;
    logic [1:0] bank;
    logic [7:0] reg_a;
    logic [7:0] ptr_a;
    logic [7:0] ind_a;
    logic [7:0] src_v;
    logic [7:0] bit_byte_a;
    logic [7:0] bit_byte;
    logic [15:0] prod;
    logic [15:0] base;
    logic       dir_we;
    logic [7:0] dir_a;
    logic [7:0] dir_d;

    // Field positions inside the opcode and the bit address byte
    localparam int OP_REG_MSB   = 2;
    localparam int OP_PTR_BIT   = 0;
    localparam int BIT_IDX_MSB  = 2;
    localparam int BIT_BYTE_LSB = 3;
    localparam int BIT_BYTE_MSB = 6;

    function automatic cmx_dec_t mk(input cmx_kind_t k, input cmx_src_t sr, input cmx_dst_t ds,
                                    input logic [1:0] ln, input logic [2:0] cy);
        cmx_dec_t r;
        r = '{kind: k, src: sr, dst: ds, len: ln, cyc: cy, use_data_pointer: 1'b0, ext_wr: 1'b0};
        return r;
    endfunction

    function automatic cmx_dec_t decode(input logic [7:0] o);
        cmx_dec_t r;
        r = mk(K_BAD, SRC_ACC, DST_NONE, LEN1, CYC_ONE);
        // Anything not matched below stays unknown
        if (o[7:3] == OP5_MOV_A_RN) r = mk(K_MOV, SRC_REG, DST_ACC, LEN1, CYC_ONE);
        else if (o[7:3] == OP5_MOV_RN_A) r = mk(K_MOV, SRC_ACC, DST_REG, LEN1, CYC_ONE);
        else if (o[7:3] == OP5_MOV_RN_DIR) r = mk(K_MOV, SRC_DIR, DST_REG, LEN2, CYC_TWO);
        else if (o[7:3] == OP5_MOV_RN_IMM) r = mk(K_MOV, SRC_IMM2, DST_REG, LEN2, CYC_ONE);
        else if (o[7:3] == OP5_MOV_DIR_RN) r = mk(K_MOV, SRC_REG, DST_DIR2, LEN2, CYC_TWO);
        else if (o[7:1] == OP7_MOV_A_IND) r = mk(K_MOV, SRC_IND, DST_ACC, LEN1, CYC_ONE);
        else if (o[7:1] == OP7_MOV_DIR_IND) r = mk(K_MOV, SRC_IND, DST_DIR2, LEN2, CYC_TWO);
        else if (o[7:1] == OP7_MOV_IND_A) r = mk(K_MOV, SRC_ACC, DST_IND, LEN1, CYC_ONE);
        else if (o[7:1] == OP7_MOV_IND_DIR) r = mk(K_MOV, SRC_DIR, DST_IND, LEN2, CYC_TWO);
        else if (o[7:1] == OP7_MOV_IND_IMM) r = mk(K_MOV, SRC_IMM2, DST_IND, LEN2, CYC_ONE);
        else if (o[7:1] == OP7_EXTERNAL_DATA_TRANSFER_RD_RI) r = mk(K_EXTERNAL_DATA_TRANSFER, SRC_ACC, DST_NONE, LEN1, CYC_TWO);
        else if (o[7:1] == OP7_EXTERNAL_DATA_TRANSFER_WR_RI) begin
            r = mk(K_EXTERNAL_DATA_TRANSFER, SRC_ACC, DST_NONE, LEN1, CYC_TWO);
            r.ext_wr = 1'b1;
        end
        else if (o == OP_MOV_A_DIR) r = mk(K_MOV, SRC_DIR, DST_ACC, LEN2, CYC_ONE);
        else if (o == OP_MOV_A_IMM) r = mk(K_MOV, SRC_IMM2, DST_ACC, LEN2, CYC_ONE);
        else if (o == OP_MOV_DIR_A) r = mk(K_MOV, SRC_ACC, DST_DIR2, LEN2, CYC_ONE);
        else if (o == OP_MOV_DIR_DIR) r = mk(K_MOV, SRC_DIR, DST_DIR3, LEN3, CYC_TWO);
        else if (o == OP_MOV_DIR_IMM) r = mk(K_MOV, SRC_IMM3, DST_DIR2, LEN3, CYC_TWO);
        else if (o == OP_MOV_C_BIT) r = mk(K_BIT_LD, SRC_ACC, DST_NONE, LEN2, CYC_ONE);
        else if (o == OP_MOV_BIT_C) r = mk(K_BIT_ST, SRC_ACC, DST_NONE, LEN2, CYC_TWO);
        else if (o == OP_MOV_DATA_POINTER) r = mk(K_DATA_POINTER, SRC_ACC, DST_NONE, LEN3, CYC_TWO);
        else if (o == OP_CODE_TABLE_READ_PC) r = mk(K_CODE_TABLE_READ, SRC_ACC, DST_NONE, LEN1, CYC_TWO);
        else if (o == OP_CODE_TABLE_READ_DP) begin
            r = mk(K_CODE_TABLE_READ, SRC_ACC, DST_NONE, LEN1, CYC_TWO);
            r.use_data_pointer = 1'b1;
        end
        else if (o == OP_EXTERNAL_DATA_TRANSFER_RD_DP) begin
            r = mk(K_EXTERNAL_DATA_TRANSFER, SRC_ACC, DST_NONE, LEN1, CYC_TWO);
            r.use_data_pointer = 1'b1;
        end
        else if (o == OP_EXTERNAL_DATA_TRANSFER_WR_DP) begin
            r = mk(K_EXTERNAL_DATA_TRANSFER, SRC_ACC, DST_NONE, LEN1, CYC_TWO);
            r.use_data_pointer = 1'b1;
            r.ext_wr   = 1'b1;
        end
        else if (o == OP_MUL) r = mk(K_MUL, SRC_ACC, DST_NONE, LEN1, CYC_MUL);
        else if (o == OP_NOP) r = mk(K_NOP, SRC_ACC, DST_NONE, LEN1, CYC_ONE);
        return r;
    endfunction

    // Direct space: low half is RAM, upper half the special registers; unmapped reads zero
    function automatic logic [7:0] rd_dir(input cmx_state_t st, input logic [7:0] a);
        logic [7:0] v;
        v = 8'h00;
        if (!a[DIR_SFR_BIT]) v = st.ram[a];
        else if (a == SFR_ACC) v = st.acc;
        else if (a == SFR_B) v = st.b;
        else if (a == SFR_PSW) v = st.psw;
        else if (a == SFR_DPL) v = st.pointer_low_byte;
        else if (a == SFR_DPH) v = st.pointer_high_byte;
        else if (a == SFR_P2) v = st.p2;
        return v;
    endfunction

    // Byte that holds a bit: bit RAM below the special area, the register itself above
    function automatic logic [7:0] bit_byte_addr(input logic [7:0] a);
        logic [7:0] r;
        r = 8'(BITRAM_BASE + {4'h0, a[BIT_BYTE_MSB:BIT_BYTE_LSB]});
        if (a[DIR_SFR_BIT]) r = {a[DIR_SFR_BIT:BIT_BYTE_LSB], 3'h0};
        return r;
    endfunction

    // Direct-space write; unmapped special addresses swallow the write
    function automatic cmx_state_t wr_dir(input cmx_state_t st, input logic [7:0] a, input logic [7:0] d);
        cmx_state_t r;
        r = st;
        if (!a[DIR_SFR_BIT]) r.ram[a] = d;
        else if (a == SFR_ACC) r.acc = d;
        else if (a == SFR_B) r.b = d;
        else if (a == SFR_PSW) r.psw = d;
        else if (a == SFR_DPL) r.pointer_low_byte = d;
        else if (a == SFR_DPH) r.pointer_high_byte = d;
        else if (a == SFR_P2) r.p2 = d;
        return r;
    endfunction

    always_comb begin
        s_next = s_reg;
        s_next.done = 1'b0;
        s_next.bad = 1'b0;
        s_next.p0_meta = P0_IN;
        s_next.p0_sync = s_reg.p0_meta;
        op = CODE_DATA[7:0];
        byte2 = CODE_DATA[15:8];
        byte3 = CODE_DATA[23:16];
        dec = decode(op);
        bank = s_reg.psw[PSW_RS1:PSW_RS0];
        reg_a = {3'h0, bank, op[OP_REG_MSB:0]};
        // Pointer registers are R0 and R1 of the current bank
        ptr_a = {3'h0, bank, 2'h0, op[OP_PTR_BIT]};
        ind_a = s_reg.ram[ptr_a];
        bit_byte_a = bit_byte_addr(byte2);
        bit_byte = rd_dir(s_reg, bit_byte_a);
        // Full product in one step; the remaining multiply cycles are padding
        prod = s_reg.acc * s_reg.b;
        base = 16'h0000;
        dir_we = 1'b0;
        dir_a = byte2;
        dir_d = 8'h00;
        case (dec.src)
            SRC_REG:  src_v = s_reg.ram[reg_a];
            SRC_DIR:  src_v = rd_dir(s_reg, byte2);
            SRC_IND:  src_v = s_reg.ram[ind_a];
            SRC_IMM2: src_v = byte2;
            SRC_IMM3: src_v = byte3;
            default:  src_v = s_reg.acc;
        endcase
        case (s_reg.fsm)
            FS_EXEC: begin
                s_next.pc = 16'(s_reg.pc + {14'h0000, dec.len});
                s_next.code_addr = s_next.pc;
                s_next.cnt = 3'(dec.cyc - CYC_ONE);
                s_next.fsm = (dec.cyc > CYC_ONE) ? FS_WAIT : FS_EXEC;
                s_next.done = (dec.cyc == CYC_ONE);
                case (dec.kind)
                    K_MOV: begin
                        case (dec.dst)
                            DST_ACC: s_next.acc = src_v;
                            DST_REG: s_next.ram[reg_a] = src_v;
                            DST_IND: s_next.ram[ind_a] = src_v;
                            DST_DIR2: begin
                                dir_we = 1'b1;
                                dir_d = src_v;
                            end
                            DST_DIR3: begin
                                dir_we = 1'b1;
                                dir_a = byte3;
                                dir_d = src_v;
                            end
                            default: ;
                        endcase
                    end
                    K_BIT_LD: s_next.psw[PSW_CY] = bit_byte[byte2[BIT_IDX_MSB:0]];
                    K_BIT_ST: begin
                        // Read-modify-write of the holding byte; its other bits go back unchanged
                        dir_we = 1'b1;
                        dir_a = bit_byte_a;
                        dir_d = bit_byte;
                        dir_d[byte2[BIT_IDX_MSB:0]] = s_reg.psw[PSW_CY];
                    end
                    K_DATA_POINTER: begin
                        s_next.pointer_high_byte = byte2;
                        s_next.pointer_low_byte = byte3;
                    end
                    K_CODE_TABLE_READ: begin
                        // Second cycle fetches the table byte at base plus accumulator
                        base = dec.use_data_pointer ? {s_reg.pointer_high_byte, s_reg.pointer_low_byte} : s_next.pc;
                        s_next.code_addr = 16'(base + {8'h00, s_reg.acc});
                        s_next.fsm = FS_TABLE;
                        s_next.done = 1'b0;
                    end
                    K_EXTERNAL_DATA_TRANSFER: begin
                        // Address phase first so the external latch holds the low byte before data drives
                        s_next.xwr = dec.ext_wr;
                        s_next.xdptr = dec.use_data_pointer;
                        s_next.xbus.ale = 1'b1;
                        s_next.xbus.p0_oe_n = 1'b0;
                        s_next.xbus.p0_out = dec.use_data_pointer ? s_reg.pointer_low_byte : ind_a;
                        s_next.fsm = FS_XDATA;
                        s_next.done = 1'b0;
                    end
                    K_MUL: begin
                        s_next.acc = prod[7:0];
                        s_next.b = prod[15:8];
                        s_next.psw[PSW_OV] = |prod[15:8];
                        s_next.psw[PSW_CY] = 1'b0;
                    end
                    // Outside the subset: flagged and skipped as a one-byte idle
                    K_BAD: s_next.bad = 1'b1;
                    default: ;
                endcase
            end
            FS_WAIT: begin
                // State was updated at the execute edge; only the length is padded here
                s_next.cnt = 3'(s_reg.cnt - CYC_ONE);
                if (s_reg.cnt == CYC_ONE) begin
                    s_next.fsm = FS_EXEC;
                    s_next.done = 1'b1;
                end
            end
            FS_TABLE: begin
                // Code bus carries the table byte now, then returns to the program counter
                s_next.acc = CODE_DATA[7:0];
                s_next.code_addr = s_reg.pc;
                s_next.fsm = FS_EXEC;
                s_next.done = 1'b1;
            end
            FS_XDATA: begin
                // Data phase: a write drives the accumulator, a read lets go of port zero
                s_next.xbus.ale = 1'b0;
                if (s_reg.xwr) begin
                    s_next.xbus.p0_out = s_reg.acc;
                    s_next.xbus.wr_n = 1'b0;
                end else begin
                    s_next.xbus.p0_oe_n = 1'b1;
                    s_next.xbus.rd_n = 1'b0;
                end
                s_next.cnt = XSYNC_WAIT;
                s_next.fsm = FS_XCAPT;
            end
            FS_XCAPT: begin
                // Read data needs two synchroniser edges after the strobe falls
                s_next.cnt = 3'(s_reg.cnt - CYC_ONE);
                if (s_reg.cnt == 3'h0) begin
                    if (!s_reg.xwr) s_next.acc = s_reg.p0_sync;
                    s_next.xbus.rd_n = 1'b1;
                    s_next.xbus.wr_n = 1'b1;
                    s_next.xbus.p0_oe_n = 1'b1;
                    s_next.xdptr = 1'b0;
                    s_next.cnt = 3'h0;
                    s_next.fsm = FS_EXEC;
                    s_next.done = 1'b1;
                end
            end
            default: s_next.fsm = FS_EXEC;
        endcase
        if (dir_we) s_next = wr_dir(s_next, dir_a, dir_d);
        // Port two shows the pointer high byte only during a pointer transfer; latch is untouched
        s_next.xbus.p2_out = s_next.xdptr ? s_reg.pointer_high_byte : s_next.p2;
    end

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            // Port latch, port zero enable and strobes rest high; everything else, RAM included, clears
            s_reg <= '0;
            s_reg.p2 <= P2_RESET;
            s_reg.xbus.p2_out <= P2_RESET;
            s_reg.xbus.p0_oe_n <= 1'b1;
            s_reg.xbus.rd_n <= 1'b1;
            s_reg.xbus.wr_n <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign CODE_ADDR = s_reg.code_addr;
    assign XBUS = s_reg.xbus;
    assign CORE = '{acc: s_reg.acc, b: s_reg.b, psw: s_reg.psw, pointer_high_byte: s_reg.pointer_high_byte, pointer_low_byte: s_reg.pointer_low_byte, pc: s_reg.pc};
    assign INSN_DONE = s_reg.done;
    assign INSN_UNKNOWN = s_reg.bad;
endmodule
`default_nettype wire

// ---- cmx_exec_chk.sv ----
/* Port-level checker for the move and multiply core.
   Sees only the top ports; bound from the testbench top file. */
`timescale 1ns/1ps
`default_nettype none
module cmx_exec_chk
    import cmx_pkg::*;
(
    input wire logic        CLK,
    input wire logic        RSTN,
    input wire logic [15:0] CODE_ADDR,
    input wire logic [23:0] CODE_DATA,
    input wire logic [7:0]  P0_IN,
    input wire cmx_xbus_t   XBUS,
    input wire cmx_core_t   CORE,
    input wire logic        INSN_DONE,
    input wire logic        INSN_UNKNOWN
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);
    logic [7:0] op;
    assign op = CODE_DATA[7:0];
    sequence s_addr;
        XBUS.ale && !XBUS.p0_oe_n;
    endsequence
    sequence s_wr;
        (!XBUS.wr_n && !XBUS.p0_oe_n && XBUS.rd_n)[*3] ##1 (XBUS.wr_n && XBUS.p0_oe_n);
    endsequence
    sequence s_rd;
        (!XBUS.rd_n && XBUS.p0_oe_n && XBUS.wr_n)[*3] ##1 XBUS.rd_n;
    endsequence
    a_ale_addr_phase: assert property ($rose(XBUS.ale) |-> s_addr ##1 !XBUS.ale)
        else $error("address phase wrong");
    a_strobe_after_ale: assert property (XBUS.ale |=> (!XBUS.wr_n || !XBUS.rd_n))
        else $error("no strobe after address");
    a_write_phase: assert property ($fell(XBUS.wr_n) |-> s_wr)
        else $error("write strobe wrong");
    a_read_phase: assert property ($fell(XBUS.rd_n) |-> s_rd)
        else $error("read strobe wrong");
    a_high_addr_held: assert property ((!XBUS.rd_n || !XBUS.wr_n) |-> $stable(XBUS.p2_out))
        else $error("port two moved in strobe");
    a_mul_result: assert property (INSN_DONE && op == OP_MUL |=>
        {CORE.b, CORE.acc} == 16'($past(CORE.acc)) * 16'($past(CORE.b)) && !CORE.psw[PSW_CY]
        && CORE.psw[PSW_OV] == (CORE.b != 8'h00))
        else $error("product or flags wrong");
    a_mul_cycles: assert property (INSN_DONE && op == OP_MUL |=> !INSN_DONE[*3] ##1 INSN_DONE)
        else $error("multiply length wrong");
    a_idle_pc_only: assert property (INSN_DONE && op == OP_NOP |=> INSN_DONE
        && CORE.pc == $past(CORE.pc) + 16'h1 && $stable({CORE.acc, CORE.b, CORE.psw, CORE.pointer_high_byte, CORE.pointer_low_byte}))
        else $error("idle changed state");
    a_imm_to_acc: assert property (INSN_DONE && op == OP_MOV_A_IMM |=> INSN_DONE
        && CORE.acc == $past(CODE_DATA[15:8]))
        else $error("immediate load wrong");
    a_pointer_load: assert property (INSN_DONE && op == OP_MOV_DATA_POINTER |=> !INSN_DONE ##1 (INSN_DONE
        && {CORE.pointer_high_byte, CORE.pointer_low_byte} == {$past(CODE_DATA[15:8], 2), $past(CODE_DATA[23:16], 2)}))
        else $error("pointer load wrong");
endmodule
`default_nettype wire

// ---- cmx_mem_model.sv ----
/* Program memory and multiplexed external data memory model.
   Assumes the testbench fills prog and xram through hierarchy. */
`timescale 1ns/1ps
`default_nettype none
module cmx_mem_model
    import cmx_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic [15:0] CODE_ADDR,
    output logic      [23:0] CODE_DATA,
    input  wire cmx_xbus_t   XBUS,
    output logic      [7:0]  P0_IN
);
    logic [7:0]  prog [0:65535];
    logic [7:0]  xram [0:65535];
    logic [15:0] xadr;
    logic [7:0]  p0_last = 8'h00;
    assign CODE_DATA = {prog[CODE_ADDR + 16'h2], prog[CODE_ADDR + 16'h1], prog[CODE_ADDR]};
    // Released bus shows the inverse of its last level, never a stale byte
    assign P0_IN = XBUS.rd_n ? ~p0_last : xram[xadr];
    always @(posedge CLK) begin
        p0_last <= P0_IN;
        if (XBUS.ale) xadr <= {XBUS.p2_out, XBUS.p0_out};
        if (!XBUS.wr_n) xram[xadr] <= XBUS.p0_out;
    end
endmodule
`default_nettype wire

// ---- cmx_pkg.sv ----
/*
 Constants, encodings and carrier types for the move and multiply execution core.
 Assumes one 250 MHz clock and a program memory that answers combinationally.
*/
package cmx_pkg;
    localparam logic [4:0] OP5_MOV_A_RN    = 5'h1d;
    localparam logic [4:0] OP5_MOV_RN_A    = 5'h1f;
    localparam logic [4:0] OP5_MOV_RN_DIR  = 5'h15;
    localparam logic [4:0] OP5_MOV_RN_IMM  = 5'h0f;
    localparam logic [4:0] OP5_MOV_DIR_RN  = 5'h11;
    localparam logic [6:0] OP7_MOV_A_IND   = 7'h73;
    localparam logic [6:0] OP7_MOV_DIR_IND = 7'h43;
    localparam logic [6:0] OP7_MOV_IND_A   = 7'h7b;
    localparam logic [6:0] OP7_MOV_IND_DIR = 7'h53;
    localparam logic [6:0] OP7_MOV_IND_IMM = 7'h3b;
    localparam logic [6:0] OP7_EXTERNAL_DATA_TRANSFER_RD_RI  = 7'h71;
    localparam logic [6:0] OP7_EXTERNAL_DATA_TRANSFER_WR_RI  = 7'h79;
    localparam logic [7:0] OP_MOV_A_DIR    = 8'he5;
    localparam logic [7:0] OP_MOV_A_IMM    = 8'h74;
    localparam logic [7:0] OP_MOV_DIR_A    = 8'hf5;
    localparam logic [7:0] OP_MOV_DIR_DIR  = 8'h85;
    localparam logic [7:0] OP_MOV_DIR_IMM  = 8'h75;
    localparam logic [7:0] OP_MOV_C_BIT    = 8'ha2;
    localparam logic [7:0] OP_MOV_BIT_C    = 8'h92;
    localparam logic [7:0] OP_MOV_DATA_POINTER     = 8'h90;
    localparam logic [7:0] OP_CODE_TABLE_READ_DP      = 8'h93;
    localparam logic [7:0] OP_CODE_TABLE_READ_PC      = 8'h83;
    localparam logic [7:0] OP_EXTERNAL_DATA_TRANSFER_RD_DP   = 8'he0;
    localparam logic [7:0] OP_EXTERNAL_DATA_TRANSFER_WR_DP   = 8'hf0;
    localparam logic [7:0] OP_MUL          = 8'ha4;
    localparam logic [7:0] OP_NOP          = 8'h00;
    localparam logic [7:0] SFR_ACC         = 8'he0;
    localparam logic [7:0] SFR_B           = 8'hf0;
    localparam logic [7:0] SFR_PSW         = 8'hd0;
    localparam logic [7:0] SFR_DPL         = 8'h82;
    localparam logic [7:0] SFR_DPH         = 8'h83;
    localparam logic [7:0] SFR_P2          = 8'ha0;
    localparam logic [7:0] BITRAM_BASE     = 8'h20;
    localparam int         DIR_SFR_BIT     = 7;
    localparam int         PSW_CY          = 7;
    localparam int         PSW_RS1         = 4;
    localparam int         PSW_RS0         = 3;
    localparam int         PSW_OV          = 2;
    localparam logic [7:0] P2_RESET        = 8'hff;
    localparam logic [1:0] LEN1            = 2'h1;
    localparam logic [1:0] LEN2            = 2'h2;
    localparam logic [1:0] LEN3            = 2'h3;
    localparam logic [2:0] CYC_ONE         = 3'h1;
    localparam logic [2:0] CYC_TWO         = 3'h2;
    localparam logic [2:0] CYC_MUL         = 3'h4;
    localparam logic [2:0] XSYNC_WAIT      = 3'h2;

    typedef enum logic [2:0] {SRC_ACC, SRC_REG, SRC_DIR, SRC_IND, SRC_IMM2, SRC_IMM3} cmx_src_t;
    typedef enum logic [2:0] {DST_NONE, DST_ACC, DST_REG, DST_DIR2, DST_DIR3, DST_IND} cmx_dst_t;
    typedef enum logic [3:0] {K_NOP, K_MOV, K_BIT_LD, K_BIT_ST, K_DATA_POINTER, K_CODE_TABLE_READ, K_EXTERNAL_DATA_TRANSFER, K_MUL, K_BAD} cmx_kind_t;
    typedef enum logic [2:0] {FS_EXEC, FS_WAIT, FS_TABLE, FS_XDATA, FS_XCAPT} cmx_fsm_t;

    typedef struct packed {
        cmx_kind_t  kind;
        cmx_src_t   src;
        cmx_dst_t   dst;
        logic [1:0] len;
        logic [2:0] cyc;
        logic       use_data_pointer;
        logic       ext_wr;
    } cmx_dec_t;

    typedef struct packed {
        logic [7:0] p0_out;
        logic       p0_oe_n;
        logic [7:0] p2_out;
        logic       ale;
        logic       rd_n;
        logic       wr_n;
    } cmx_xbus_t;

    typedef struct packed {
        logic [7:0]  acc;
        logic [7:0]  b;
        logic [7:0]  psw;
        logic [7:0]  pointer_high_byte;
        logic [7:0]  pointer_low_byte;
        logic [15:0] pc;
    } cmx_core_t;
endpackage

// ---- test_cpu_move_multiply_exec.sv ----
/* Self-checking testbench: runs short programs from reset and checks state.
   Assumes the memory model answers program fetches combinationally. */
`timescale 1ns/1ps
`default_nettype none
module test_cpu_move_multiply_exec;
    import cmx_pkg::*;
    logic        CLK  = 1'b0;
    logic        RSTN = 1'b0;
    logic [15:0] code_addr;
    logic [23:0] code_data;
    logic [7:0]  p0_in;
    cmx_xbus_t   xbus;
    cmx_core_t   core;
    logic        done;
    logic        unk;
    int          n_unk = 0;
    int          n_fail = 0;
    int          check_count = 0;
    logic [31:0] seed = 32'h6a46de38;
    always #2 CLK = ~CLK;
    cmx_exec u_dut(.CLK(CLK), .RSTN(RSTN), .CODE_ADDR(code_addr), .CODE_DATA(code_data), .P0_IN(p0_in),
        .XBUS(xbus), .CORE(core), .INSN_DONE(done), .INSN_UNKNOWN(unk));
    cmx_mem_model u_mem(.CLK(CLK), .CODE_ADDR(code_addr), .CODE_DATA(code_data), .XBUS(xbus), .P0_IN(p0_in));
    function automatic logic [7:0] rnd();
        for (int i = 0; i < 8; i++) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed[7:0];
    endfunction
    function automatic logic [7:0] bit_into(input logic [7:0] v, input int pos, input logic c);
        logic [7:0] r;
        r = v;
        r[pos] = c;
        return r;
    endfunction
    // Flags after the product and the carry reload from accumulator bit 7
    function automatic logic [7:0] psw_expect(input logic [15:0] p);
        return {p[7], 4'h0, p > 16'h00ff, 2'h0};
    endfunction
    always @(posedge CLK) begin
        if (!RSTN) n_unk <= 0;
        else if (unk) n_unk <= n_unk + 1;
    end
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic load(input logic [7:0] code [$]);
        @(posedge CLK) RSTN <= 1'b0;
        // Swap the program only once the core sits in reset
        @(posedge CLK);
        for (int i = 0; i < 65536; i++) u_mem.prog[i] = 8'h00;
        foreach (code[i]) u_mem.prog[i] = code[i];
    endtask
    task automatic go(input int ncyc);
        repeat (20) @(posedge CLK);
        RSTN <= 1'b1;
        repeat (ncyc) @(posedge CLK);
    endtask
    initial begin
        #200000;
        n_fail++;
        conclude();
    end
    initial begin
        logic [7:0]  a, b, v, w, hi, lo, t1, t2;
        logic [15:0] p;
        for (int i = 0; i < 65536; i++) u_mem.xram[i] = rnd();
        for (int i = 0; i < 7; i++) begin
            a = i == 0 ? 8'hff : i == 1 ? 8'h10 : i == 2 ? 8'h0f : rnd();
            b = i == 0 ? 8'hff : i == 1 ? 8'h10 : i == 2 ? 8'h11 : rnd();
            p = 16'(a) * 16'(b);
            load({8'h00, 8'h74, 8'hff, 8'ha2, 8'he7, 8'h74, a, 8'h75, 8'hf0, b, 8'ha4,
                  8'ha2, 8'he7, 8'h92, 8'hf3});
            go(30);
            chk("acc", {8'h00, p[7:0]}, {8'h00, core.acc});
            chk("b", {8'h00, bit_into(p[15:8], 3, p[7])}, {8'h00, core.b});
            chk("psw", {8'h00, psw_expect(p)}, {8'h00, core.psw});
        end
        for (int i = 0; i < 3; i++) begin
            v = rnd();
            w = rnd();
            load({8'h00, 8'h74, v, 8'hf5, 8'hf0, 8'h75, 8'he0, 8'h00, 8'he5, 8'hf0, 8'hac, 8'hf0,
                  8'h7d, w, 8'h8d, 8'h82, 8'h79, 8'h41, 8'ha7, 8'h82, 8'h74, 8'h00, 8'he7,
                  8'h85, 8'hf0, 8'h83, 8'h75, 8'hf0, 8'h00, 8'h8c, 8'hf0});
            go(40);
            chk("acc", {8'h00, w}, {8'h00, core.acc});
            chk("b", {8'h00, v}, {8'h00, core.b});
            chk("data_pointer", {v, w}, {core.pointer_high_byte, core.pointer_low_byte});
            chk("psw", 16'h0000, {8'h00, core.psw});
        end
        for (int i = 0; i < 3; i++) begin
            hi = 8'h10 | (rnd() & 8'h6f);
            lo = 8'hf0 | rnd();
            a = rnd();
            b = 8'h80 | rnd();
            t1 = rnd();
            t2 = rnd();
            load({8'h00, 8'h90, hi, lo, 8'h74, a, 8'h93, 8'hf5, 8'hf0, 8'h74, b, 8'h83});
            u_mem.prog[{hi, lo} + 16'(a)] = t1;
            u_mem.prog[16'd12 + 16'(b)] = t2;
            go(30);
            chk("b", {8'h00, t1}, {8'h00, core.b});
            chk("acc", {8'h00, t2}, {8'h00, core.acc});
            chk("data_pointer", {hi, lo}, {core.pointer_high_byte, core.pointer_low_byte});
        end
        for (int i = 0; i < 3; i++) begin
            a = rnd();
            v = rnd();
            w = rnd();
            hi = rnd() & 8'h7f;
            lo = rnd();
            load({8'h00, 8'h78, a, 8'h74, v, 8'hf2, 8'h74, 8'h00, 8'he2, 8'hf5, 8'hf0,
                  8'h90, hi, lo, 8'h74, w, 8'hf0, 8'h74, 8'h00, 8'he0, 8'h04});
            go(60);
            chk("xram ri", {8'h00, v}, {8'h00, u_mem.xram[{8'hff, a}]});
            chk("b", {8'h00, v}, {8'h00, core.b});
            chk("xram dp", {8'h00, w}, {8'h00, u_mem.xram[{hi, lo}]});
            chk("acc", {8'h00, w}, {8'h00, core.acc});
            chk("p2", {8'h00, P2_RESET}, {8'h00, xbus.p2_out});
            chk("unknown", 16'h0001, 16'(n_unk));
        end
        conclude();
    end
endmodule
bind cmx_exec cmx_exec_chk u_chk(.CLK(CLK), .RSTN(RSTN), .CODE_ADDR(CODE_ADDR), .CODE_DATA(CODE_DATA),
    .P0_IN(P0_IN), .XBUS(XBUS), .CORE(CORE), .INSN_DONE(INSN_DONE), .INSN_UNKNOWN(INSN_UNKNOWN));
`default_nettype wire
